// file: core/ee_defines.svh
// Constants for the serial EEPROM command port: encodings, field ends,
// timing figures. Included by the package and the design modules.
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

`define EE_OP_EXT        2'h0
`define EE_OP_WRITE      2'h1
`define EE_OP_READ       2'h2
`define EE_OP_ERASE      2'h3

`define EE_EXT_LOCK      2'h0
`define EE_EXT_BULK_WR   2'h1
`define EE_EXT_BULK_ER   2'h2
`define EE_EXT_UNLOCK    2'h3

// Field ends counted after the lead bit; word widths in bits
`define EE_ADDR_END_X16  5'h0c
`define EE_ADDR_END_X8   5'h0d
`define EE_DATA_END_X16  5'h1c
`define EE_DATA_END_X8   5'h15
`define EE_WIDTH_X16     5'h10
`define EE_WIDTH_X8      5'h08

`define EE_BADDR_W       11
`define EE_MEM_BYTES     2048
`define EE_MASK_LARGE    11'h7ff
`define EE_MASK_SMALL    11'h3ff
`define EE_ERASED_BYTE   8'hff

`define EE_CLK_PER_MS    100000
`define EE_T_WORD_MS     5
`define EE_T_BULK_ER_MS  15
`define EE_T_BULK_WR_MS  30
`define EE_TMR_W         22
`define EE_FIFO_DEPTH    8

`endif

// file: core/ee_pkg.sv
// Types shared by the serial EEPROM command port and its queue.
// Assumes ee_defines.svh is on the include path.
`include "ee_defines.svh"

package ee_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_CMD    = 4'h2,
    ST_READ   = 4'h4,
    ST_STATUS = 4'h8
  } cmd_state_t;

  typedef enum logic [1:0] {
    PK_WRITE   = 2'h0,
    PK_ERASE   = 2'h1,
    PK_BULK_ER = 2'h2,
    PK_BULK_WR = 2'h3
  } prog_kind_t;

  typedef struct packed {
    prog_kind_t                 kind;
    logic                       wide;
    logic [`EE_BADDR_W-1:0]     addr;
    logic [15:0]                data;
  } prog_req_t;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic din;
    logic wide;
  } link_pins_t;

endpackage

// file: core/prog_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a reset already synchronised to it.
`include "ee_defines.svh"

module prog_fifo #(
  parameter int unsigned WIDTH = 30,
  parameter int unsigned DEPTH = `EE_FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("prog_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem[rp_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// file: core/serial_eeprom_command_port.sv
// Command front end of a three-wire serial EEPROM, with its array,
// lock state and self-timed programming engine.
// Assumes all link pins are asynchronous to mclk and slow against it.
// Function
// - Lead bit: first serial clock rise with select and serial_in high.
// - Before a lead bit all pin activity is ignored, nothing runs.
// - Standby ends as soon as select goes high.
// - A command runs only after all its bits are shifted in.
// - After the last bit, clock and serial_in are ignored until lead bit.
// - word_width_pin high gives 16-bit words, low gives 8-bit words.
// - Command, address and data bits sampled on serial clock rise.
// - serial_out floats except for read data or completion level.
// - Completion level low while programming, high when ready.
// - serial_out floats once select falls.
// - Opcodes 10 read, 01 write, 11 erase, 00 extended by sub-code.
// - 16-bit mode: ten address positions, small part ignores the first.
// - 8-bit mode: eleven address positions, small part ignores first.
// - 16-bit mode: 16 data bits; 29 or 13 clocks per command.
// - 8-bit mode: 8 data bits; 22 or 14 clocks per command.
// - Read drives one zero, then the word most significant bit first.
// - Locked after reset until program_unlock; locked writes refused.
// - Continued clocking on a read streams following words.
// - Select low resets control; running programming still completes.
// - Programming starts on the edge taking the last needed bit; behind a busy engine it waits in the queue.
`include "ee_defines.svh"

module serial_eeprom_command_port #(
  parameter bit          LARGE_PART    = 1'b1,
  parameter int unsigned T_WORD_CYC    = `EE_T_WORD_MS * `EE_CLK_PER_MS,
  parameter int unsigned T_BULK_ER_CYC = `EE_T_BULK_ER_MS * `EE_CLK_PER_MS,
  parameter int unsigned T_BULK_WR_CYC = `EE_T_BULK_WR_MS * `EE_CLK_PER_MS,
  parameter int unsigned FIFO_DEPTH    = `EE_FIFO_DEPTH
)(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic dev_select,
  input  wire logic serial_clk,
  input  wire logic serial_in,
  input  wire logic word_width_pin,
  output logic      serial_out,
  output logic      serial_out_oe_n,
  output logic      lock_state,
  output logic      prog_busy,
  output logic      standby
);
  localparam int unsigned TW = `EE_TMR_W;

  generate
    if (T_WORD_CYC < 1 || T_BULK_ER_CYC < 1 || T_BULK_WR_CYC < 1 ||
        T_WORD_CYC >= (1 << TW) || T_BULK_ER_CYC >= (1 << TW) ||
        T_BULK_WR_CYC >= (1 << TW)) begin : g_bad_timer
      $error("programming time out of timer range");
    end
  endgenerate

  logic                   rst_meta_r;
  logic                   rst_sync_n_r;
  ee_pkg::link_pins_t     pins_raw;
  ee_pkg::link_pins_t     pins_meta_r;
  ee_pkg::link_pins_t     pins_s_r;
  logic                   sclk_prev_r;
  logic                   sclk_rise;

  ee_pkg::cmd_state_t     state_r;
  ee_pkg::cmd_state_t     state_nxt;
  logic [4:0]             cnt_r;
  logic [4:0]             cnt_nxt;
  logic [27:0]            sh_r;
  logic [27:0]            sh_nxt;
  logic                   wide_r;
  logic                   wide_nxt;
  logic [1:0]             op_r;
  logic [1:0]             op_nxt;
  logic [1:0]             sub_r;
  logic [1:0]             sub_nxt;
  logic [`EE_BADDR_W-1:0] addr_r;
  logic [`EE_BADDR_W-1:0] addr_nxt;
  logic [15:0]            rd_sh_r;
  logic [15:0]            rd_sh_nxt;
  logic [4:0]             rd_left_r;
  logic [4:0]             rd_left_nxt;
  logic                   so_r;
  logic                   so_nxt;
  logic                   oe_n_r;
  logic                   oe_n_nxt;
  logic                   lock_r;
  logic                   lock_nxt;
  logic                   busy_r;
  logic                   standby_r;
  logic                   standby_nxt;

  logic                   do_exec;
  ee_pkg::prog_kind_t     exec_kind;
  logic                   push;
  ee_pkg::prog_req_t      push_req;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  ee_pkg::prog_req_t      fifo_out;

  logic                   eng_busy_r;
  logic                   eng_busy_nxt;
  logic [TW-1:0]          tmr_r;
  logic [TW-1:0]          tmr_nxt;
  ee_pkg::prog_req_t      cur_r;
  ee_pkg::prog_req_t      cur_nxt;
  logic                   apply;
  logic                   busy;

  logic [7:0]             mem [`EE_MEM_BYTES];
  logic [`EE_BADDR_W-1:0] byte_mask;
  logic [27:0]            cmd_sh;
  logic [`EE_BADDR_W-1:0] ba_now;
  logic [`EE_BADDR_W-1:0] addr_next;
  logic [15:0]            word_ba;
  logic [15:0]            word_next;
  logic [4:0]             addr_end;
  logic [4:0]             data_end;
  logic [4:0]             width;

  // Reset release and pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  assign pins_raw = '{sel: dev_select, sclk: serial_clk, din: serial_in,
                      wide: word_width_pin};

  always_ff @(posedge mclk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      pins_meta_r <= '0;
      pins_s_r    <= '0;
      sclk_prev_r <= 1'b0;
    end else begin
      pins_meta_r <= pins_raw;
      pins_s_r    <= pins_meta_r;
      sclk_prev_r <= pins_s_r.sclk;
    end
  end

  assign sclk_rise = pins_s_r.sclk & ~sclk_prev_r;

  // Field decode; small part drops the top address position
  assign byte_mask = LARGE_PART ? `EE_MASK_LARGE
                                : `EE_MASK_SMALL;
  assign cmd_sh    = {sh_r[26:0], pins_s_r.din};
  assign ba_now    = (wide_r ? {cmd_sh[9:0], 1'b0} : cmd_sh[10:0]) & byte_mask;
  assign addr_next = (addr_r + (wide_r ? 11'h002 : 11'h001)) & byte_mask;
  assign addr_end  = wide_r ? `EE_ADDR_END_X16
                            : `EE_ADDR_END_X8;
  assign data_end  = wide_r ? `EE_DATA_END_X16
                            : `EE_DATA_END_X8;
  assign width     = wide_r ? `EE_WIDTH_X16 : `EE_WIDTH_X8;

  // Byte view of the array; a 16-bit word keeps its high byte first
  assign word_ba   = wide_r ? {mem[{ba_now[10:1], 1'b0}],
                               mem[{ba_now[10:1], 1'b1}]}
                            : {mem[ba_now], 8'h00};
  assign word_next = wide_r ? {mem[{addr_next[10:1], 1'b0}],
                               mem[{addr_next[10:1], 1'b1}]}
                            : {mem[addr_next], 8'h00};

  assign busy = eng_busy_r | fifo_out_valid;

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    wide_nxt    = wide_r;
    op_nxt      = op_r;
    sub_nxt     = sub_r;
    addr_nxt    = addr_r;
    rd_sh_nxt   = rd_sh_r;
    rd_left_nxt = rd_left_r;
    so_nxt      = so_r;
    oe_n_nxt    = oe_n_r;
    lock_nxt    = lock_r;
    do_exec     = 1'b0;
    exec_kind   = ee_pkg::PK_WRITE;
    push        = 1'b0;
    push_req    = '0;
    standby_nxt = ~pins_s_r.sel & ~busy;
    if (!pins_s_r.sel) begin
      state_nxt = ee_pkg::ST_IDLE;
      oe_n_nxt  = 1'b1;
    end else if (sclk_rise) begin
      case (state_r)
        ee_pkg::ST_IDLE, ee_pkg::ST_STATUS: begin
          if (pins_s_r.din) begin
            state_nxt = ee_pkg::ST_CMD;
            cnt_nxt   = 5'h00;
            sh_nxt    = '0;
            wide_nxt  = pins_s_r.wide;
            oe_n_nxt  = 1'b1;
          end
        end
        ee_pkg::ST_CMD: begin
          sh_nxt  = cmd_sh;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_nxt == addr_end) begin
            op_nxt   = wide_r ? cmd_sh[11:10] : cmd_sh[12:11];
            sub_nxt  = wide_r ? cmd_sh[9:8] : cmd_sh[10:9];
            addr_nxt = ba_now;
            case (op_nxt)
              `EE_OP_READ: begin
                state_nxt   = ee_pkg::ST_READ;
                so_nxt      = 1'b0;
                oe_n_nxt    = 1'b0;
                rd_sh_nxt   = word_ba;
                rd_left_nxt = width;
              end
              `EE_OP_ERASE: begin
                do_exec   = 1'b1;
                exec_kind = ee_pkg::PK_ERASE;
              end
              `EE_OP_EXT: begin
                case (sub_nxt)
                  `EE_EXT_UNLOCK: begin
                    lock_nxt  = 1'b0;
                    state_nxt = ee_pkg::ST_IDLE;
                  end
                  `EE_EXT_LOCK: begin
                    lock_nxt  = 1'b1;
                    state_nxt = ee_pkg::ST_IDLE;
                  end
                  `EE_EXT_BULK_ER: begin
                    do_exec   = 1'b1;
                    exec_kind = ee_pkg::PK_BULK_ER;
                  end
                  default: begin
                  end
                endcase
              end
              default: begin
              end
            endcase
          end else if (cnt_nxt == data_end) begin
            do_exec   = 1'b1;
            exec_kind = (op_r == `EE_OP_WRITE) ? ee_pkg::PK_WRITE
                                               : ee_pkg::PK_BULK_WR;
          end
        end
        ee_pkg::ST_READ: begin
          if (rd_left_r == 5'h00) begin
            addr_nxt    = addr_next;
            so_nxt      = word_next[15];
            rd_sh_nxt   = {word_next[14:0], 1'b0};
            rd_left_nxt = width - 5'h01;
          end else begin
            so_nxt      = rd_sh_r[15];
            rd_sh_nxt   = {rd_sh_r[14:0], 1'b0};
            rd_left_nxt = rd_left_r - 5'h01;
          end
        end
        default: begin
          state_nxt = ee_pkg::ST_IDLE;
        end
      endcase
      if (do_exec) begin
        push_req = '{kind: exec_kind, wide: wide_r, addr: addr_nxt,
                     data: wide_r ? cmd_sh[15:0] : {8'h00, cmd_sh[7:0]}};
        // Locked or queue full: refused, pin stays floating
        if (!lock_r && fifo_in_ready) begin
          push      = 1'b1;
          state_nxt = ee_pkg::ST_STATUS;
          so_nxt    = 1'b0;
          oe_n_nxt  = 1'b0;
        end else begin
          state_nxt = ee_pkg::ST_IDLE;
        end
      end
    end else if (state_r == ee_pkg::ST_STATUS) begin
      so_nxt = ~busy;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      state_r   <= ee_pkg::ST_IDLE;
      cnt_r     <= 5'h00;
      sh_r      <= '0;
      wide_r    <= 1'b0;
      op_r      <= 2'h0;
      sub_r     <= 2'h0;
      addr_r    <= '0;
      rd_sh_r   <= 16'h0000;
      rd_left_r <= 5'h00;
      so_r      <= 1'b0;
      oe_n_r    <= 1'b1;
      lock_r    <= 1'b1;
      busy_r    <= 1'b0;
      standby_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      wide_r    <= wide_nxt;
      op_r      <= op_nxt;
      sub_r     <= sub_nxt;
      addr_r    <= addr_nxt;
      rd_sh_r   <= rd_sh_nxt;
      rd_left_r <= rd_left_nxt;
      so_r      <= so_nxt;
      oe_n_r    <= oe_n_nxt;
      lock_r    <= lock_nxt;
      busy_r    <= busy;
      standby_r <= standby_nxt;
    end
  end

  // Queue lets a host stack several programming commands
  prog_fifo #(
    .WIDTH ($bits(ee_pkg::prog_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clk       (mclk),
    .rst_n     (rst_sync_n_r),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_req),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // Self-timed engine, independent of select
  assign fifo_out_ready = ~eng_busy_r;
  assign apply          = eng_busy_r && (tmr_r == '0);

  always_comb begin
    eng_busy_nxt = eng_busy_r;
    tmr_nxt      = tmr_r;
    cur_nxt      = cur_r;
    if (fifo_out_valid && !eng_busy_r) begin
      eng_busy_nxt = 1'b1;
      cur_nxt      = fifo_out;
      case (fifo_out.kind)
        ee_pkg::PK_BULK_ER: tmr_nxt = TW'(T_BULK_ER_CYC - 1);
        ee_pkg::PK_BULK_WR: tmr_nxt = TW'(T_BULK_WR_CYC - 1);
        default:            tmr_nxt = TW'(T_WORD_CYC - 1);
      endcase
    end else if (apply) begin
      eng_busy_nxt = 1'b0;
    end else if (eng_busy_r) begin
      tmr_nxt = tmr_r - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      eng_busy_r <= 1'b0;
      tmr_r      <= '0;
      cur_r      <= '0;
    end else begin
      eng_busy_r <= eng_busy_nxt;
      tmr_r      <= tmr_nxt;
      cur_r      <= cur_nxt;
    end
  end

  // Array contents are not reset; bulk write includes its own erase
  always_ff @(posedge mclk) begin
    if (apply) begin
      case (cur_r.kind)
        ee_pkg::PK_WRITE: begin
          if (cur_r.wide) begin
            mem[{cur_r.addr[10:1], 1'b0}] <= cur_r.data[15:8];
            mem[{cur_r.addr[10:1], 1'b1}] <= cur_r.data[7:0];
          end else begin
            mem[cur_r.addr] <= cur_r.data[7:0];
          end
        end
        ee_pkg::PK_ERASE: begin
          if (cur_r.wide) begin
            mem[{cur_r.addr[10:1], 1'b0}] <= `EE_ERASED_BYTE;
            mem[{cur_r.addr[10:1], 1'b1}] <= `EE_ERASED_BYTE;
          end else begin
            mem[cur_r.addr] <= `EE_ERASED_BYTE;
          end
        end
        ee_pkg::PK_BULK_ER: begin
          for (int i = 0; i < `EE_MEM_BYTES; i++) begin
            mem[i] <= `EE_ERASED_BYTE;
          end
        end
        default: begin
          for (int i = 0; i < `EE_MEM_BYTES; i++) begin
            mem[i] <= (cur_r.wide && (i % 2 == 0)) ? cur_r.data[15:8]
                                                   : cur_r.data[7:0];
          end
        end
      endcase
    end
  end

  assign serial_out      = so_r;
  assign serial_out_oe_n = oe_n_r;
  assign lock_state      = lock_r;
  assign prog_busy       = busy_r;
  assign standby         = standby_r;
endmodule

// file: verif/ee_host_model.sv
// Host side of the link: select, serial clock and serial_in.
// Assumes mclk at 100 MHz; serial clock 160 ns, low between frames.
module ee_host_model (
  input  wire logic  mclk,
  input  wire logic  serial_out,
  input  wire logic  serial_out_oe_n,
  output logic       dev_select,
  output logic       serial_clk,
  output logic       serial_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        last_r = 1'b0;
  logic        line;
  logic [63:0] rx = 64'h0;

  initial dev_select = 1'b0;
  initial serial_clk = 1'b0;
  initial serial_in = 1'b0;

  // A floating line shows the inverse of the last driven level
  always @(posedge mclk)
    if (!serial_out_oe_n) last_r <= serial_out;
  assign line = serial_out_oe_n ? ~last_r : serial_out;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic open_frame();
    dev_select <= 1'b1;
    wait_clk(6);
  endtask

  // Data set while low; answer taken late in the high phase
  task automatic pulse(input logic b);
    serial_in <= b;
    wait_clk(8);
    serial_clk <= 1'b1;
    wait_clk(8);
    rx = {rx[62:0], line};
    serial_clk <= 1'b0;
  endtask

  // Every bit of a command is sent, most significant first
  task automatic send(input int n, input logic [63:0] v);
    for (int i = n - 1; i >= 0; i--)
      pulse(v[i]);
  endtask

  // Select drops between commands; serial_in kept apart from the output
  task automatic close_frame();
    dev_select <= 1'b0;
    serial_in <= 1'b0;
    wait_clk(8);
  endtask
endmodule

// file: verif/serial_eeprom_command_port_properties.sv
// Checker for the command port pins: output enable, completion level,
// lock changes and standby against the link activity.
// Assumes it is bound to the port's top with its word timer parameter.
module serial_eeprom_command_port_properties #(
  parameter int unsigned T_WORD_CYC = 20
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic dev_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic word_width_pin,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic lock_state,
  input wire logic prog_busy,
  input wire logic standby
);
  logic        sclk_d_r;
  logic [3:0]  age_r;
  logic [31:0] busy_len_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Age of the last pin clock rise saturates so old rises never count
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) begin
      sclk_d_r   <= 1'b0;
      age_r      <= 4'hf;
      busy_len_r <= 32'h0;
    end else begin
      sclk_d_r   <= serial_clk;
      age_r      <= (serial_clk && !sclk_d_r) ? 4'h0 :
                    (age_r == 4'hf) ? age_r : age_r + 4'h1;
      busy_len_r <= prog_busy ? busy_len_r + 32'h1 : 32'h0;
    end

  property p_reset_locked;
    $rose(rst_n) |-> lock_state && serial_out_oe_n;
  endproperty
  a_reset_locked: assert property (p_reset_locked)
    else $error("not locked or floating after reset");

  property p_wake;
    $rose(dev_select) |-> ##[1:5] !standby;
  endproperty
  a_wake: assert property (p_wake)
    else $error("standby kept after select");

  property p_desel_float;
    $fell(dev_select) |-> ##[1:5] serial_out_oe_n;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("output driven after deselect");

  property p_desel_reset;
    !dev_select [*8] |-> serial_out_oe_n && $stable(lock_state);
  endproperty
  a_desel_reset: assert property (p_desel_reset)
    else $error("activity while deselected");

  property p_lock_cause;
    $changed(lock_state) |-> dev_select && age_r <= 4'hc;
  endproperty
  a_lock_cause: assert property (p_lock_cause)
    else $error("lock changed without a clock rise");

  property p_drive_cause;
    $fell(serial_out_oe_n) |-> dev_select && age_r <= 4'h6;
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("output enabled without a clock rise");

  property p_ready_high;
    $fell(prog_busy) && !serial_out_oe_n |-> ##[0:2] serial_out;
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("no ready level after programming");

  property p_busy_low;
    $rose(serial_out) && !serial_out_oe_n && dev_select
      |-> ##[0:2] !prog_busy;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("ready level while still programming");

  property p_prog_time;
    $fell(prog_busy) |-> busy_len_r >= T_WORD_CYC;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("programming shorter than word time");
endmodule

// file: verif/serial_eeprom_command_port_tb_top.sv
// Self-checking bench for the serial EEPROM command port.
// Assumes programming timers shortened to a few tens of mclk.
`include "ee_defines.svh"

module serial_eeprom_command_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TW = 20;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic word_width_pin = 1'b1;
  logic dev_select, serial_clk, serial_in;
  logic serial_out, serial_out_oe_n, lock_state, prog_busy, standby;
  int   bad_count = 0;
  int   tests_run = 0;

  serial_eeprom_command_port #(
    .T_WORD_CYC(TW), .T_BULK_ER_CYC(40), .T_BULK_WR_CYC(60)
  ) i_dut (
    .mclk(mclk), .rst_n(rst_n), .dev_select(dev_select),
    .serial_clk(serial_clk), .serial_in(serial_in),
    .word_width_pin(word_width_pin), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .lock_state(lock_state),
    .prog_busy(prog_busy), .standby(standby)
  );

  ee_host_model i_host (
    .mclk(mclk), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .dev_select(dev_select),
    .serial_clk(serial_clk), .serial_in(serial_in)
  );

  initial forever #5 mclk = ~mclk;

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [63:0] f16(logic [1:0] op, logic [9:0] a,
                                      logic [15:0] d);
    return {35'h0, 1'b1, op, a, d};
  endfunction

  function automatic logic [63:0] f8(logic [1:0] op, logic [10:0] a,
                                     logic [7:0] d);
    return {42'h0, 1'b1, op, a, d};
  endfunction

  task automatic fr(input int n, input logic [63:0] v);
    i_host.open_frame();
    i_host.send(n, v);
  endtask

  // Bounded poll of the completion level while still selected
  task automatic wait_ready();
    int n;
    n = 0;
    while (serial_out !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk("completion level", 1'b1, serial_out);
  endtask

  task automatic prog(input int n, input logic [63:0] v);
    fr(n, v);
    wait_ready();
    i_host.close_frame();
  endtask

  task automatic rd16(input logic [9:0] a, input logic [15:0] exp);
    fr(29, f16(`EE_OP_READ, a, 16'h0));
    i_host.close_frame();
    chk("read x16", {1'b0, exp}, i_host.rx[16:0]);
  endtask

  task automatic rd8(input logic [10:0] a, input logic [7:0] exp);
    fr(22, f8(`EE_OP_READ, a, 8'h0));
    i_host.close_frame();
    chk("read x8", {1'b0, exp}, i_host.rx[8:0]);
  endtask

  task automatic t_reset();
    chk("reset lock/oe", 2'h3, {lock_state, serial_out_oe_n});
    chk("reset busy/stby", 2'h1, {prog_busy, standby});
    $display("reset test done");
  endtask

  task automatic t_lead();
    i_host.open_frame();
    chk("standby", 1'b0, standby);
    i_host.send(6, 64'h0);
    chk("no lead oe/lock", 2'h3, {serial_out_oe_n, lock_state});
    i_host.send(13, f16(`EE_OP_ERASE, 10'h005, 16'h0) >> 16);
    chk("locked erase", 2'h2, {serial_out_oe_n, prog_busy});
    i_host.close_frame();
    $display("lead bit test done");
  endtask

  task automatic t_unlock();
    fr(12, f16(`EE_OP_EXT, {`EE_EXT_UNLOCK, 8'h5a}, 16'h0) >> 17);
    i_host.close_frame();
    chk("short unlock", 1'b1, lock_state);
    fr(13, f16(`EE_OP_EXT, {`EE_EXT_UNLOCK, 8'h5a}, 16'h0) >> 16);
    chk("unlock float", 1'b1, serial_out_oe_n);
    i_host.close_frame();
    chk("unlocked", 1'b0, lock_state);
    $display("unlock test done");
  endtask

  task automatic t_rw16();
    fr(29, f16(`EE_OP_WRITE, 10'h005, 16'ha5c3));
    i_host.close_frame();
    fr(29, f16(`EE_OP_WRITE, 10'h006, 16'h3c5a));
    chk("busy level", 3'h1, {serial_out_oe_n, serial_out, prog_busy});
    i_host.send(3, 64'h0);
    chk("extra clocks", 1'b0, serial_out_oe_n);
    wait_ready();
    i_host.close_frame();
    chk("deselect float", 1'b1, serial_out_oe_n);
    fr(45, f16(`EE_OP_READ, 10'h005, 16'h0) << 16);
    i_host.close_frame();
    chk("seq read", {1'b0, 32'ha5c33c5a}, i_host.rx[32:0]);
    $display("x16 write/read test done");
  endtask

  task automatic t_x8();
    word_width_pin <= 1'b0;
    rd8(11'h00b, 8'hc3);
    prog(22, f8(`EE_OP_WRITE, 11'h7ff, 8'h5e));
    rd8(11'h7ff, 8'h5e);
    prog(14, f8(`EE_OP_ERASE, 11'h7ff, 8'h0) >> 8);
    rd8(11'h7ff, 8'hff);
    word_width_pin <= 1'b1;
    $display("x8 test done");
  endtask

  task automatic t_bulk();
    prog(29, f16(`EE_OP_EXT, {`EE_EXT_BULK_WR, 8'h00}, 16'h1234));
    rd16(10'h3ff, 16'h1234);
    prog(13, f16(`EE_OP_EXT, {`EE_EXT_BULK_ER, 8'h00}, 16'h0) >> 16);
    rd16(10'h000, 16'hffff);
    $display("bulk test done");
  endtask

  task automatic t_lock();
    fr(13, f16(`EE_OP_EXT, {`EE_EXT_LOCK, 8'h00}, 16'h0) >> 16);
    i_host.close_frame();
    chk("locked again", 1'b1, lock_state);
    fr(29, f16(`EE_OP_WRITE, 10'h000, 16'h0000));
    chk("refused write", 2'h2, {serial_out_oe_n, prog_busy});
    i_host.close_frame();
    rd16(10'h000, 16'hffff);
    $display("lock test done");
  endtask

  // Full run is near 7200 mclk; the limit leaves ample margin
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    t_reset();
    t_lead();
    t_unlock();
    t_rw16();
    t_x8();
    t_bulk();
    t_lock();
    print_verdict();
  end
endmodule

bind serial_eeprom_command_port serial_eeprom_command_port_properties #(
  .T_WORD_CYC(T_WORD_CYC)
) i_props (
  .mclk(mclk), .rst_n(rst_n), .dev_select(dev_select),
  .serial_clk(serial_clk), .serial_in(serial_in),
  .word_width_pin(word_width_pin), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .lock_state(lock_state),
  .prog_busy(prog_busy), .standby(standby)
);
